/* File: uic_pkg.sv */
// Constants shared by the USB device control register block
package uic_pkg;
	// ****************************************
	// Bus and widths
	// ****************************************
	localparam int DATA_W = 32;
	localparam int REG_W = 16;
	localparam int NUM_EP = 6;
	localparam int SETUP_N = 8;
	localparam int CNT_W = 8;
	// ****************************************
	// Register indexes, byte address is four times the index
	// ****************************************
	localparam logic [29:0] IDX_FLAGS = 30'h1ff85e8;
	localparam logic [29:0] IDX_IRQ_CLR = 30'h1ff85ea;
	localparam logic [29:0] IDX_SOFT_RST = 30'h1ff85ec;
	localparam logic [29:0] IDX_STALL = 30'h1ff85ee;
	localparam logic [29:0] IDX_SETUP_12 = 30'h1ff85f0;
	localparam logic [29:0] IDX_SETUP_34 = 30'h1ff85f2;
	localparam logic [29:0] IDX_SETUP_56 = 30'h1ff85f4;
	localparam logic [29:0] IDX_SETUP_78 = 30'h1ff85f6;
	localparam logic [29:0] IDX_IRQ_MASK = 30'h1ff85f8;
	// ****************************************
	// Interrupt-clear, buffer-handoff and soft reset fields
	// ****************************************
	localparam int CLR_EP4 = 14;
	localparam int CLR_EP2 = 13;
	localparam int CLR_BUS_RST = 12;
	localparam int EP5_EMPTY = 11;
	localparam int EP5_FULL = 10;
	localparam int EP0_EMPTY = 9;
	localparam int EP0_FULL = 8;
	localparam int CLR_SUSP = 7;
	localparam int RESUME = 6;
	localparam int SRST_BIT = 0;
	// ****************************************
	// Interrupt flag fields
	// ****************************************
	localparam int FLG_SUSP_ST = 13;
	localparam logic [15:0] STICKY_MASK = 16'hc1bf;
	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [15:0] STALL_RST = 16'h0001;
	localparam logic [15:0] MASK_RST = 16'h0000;
	localparam int SRST_HOLD_DEF = 4;
endpackage : uic_pkg

/* File: uic_regs.sv */
// USB device interrupt-clear, soft reset, stall and setup capture registers
// Behaviour
// - Writing one to bits 14, 13, 12 clears endpoint 4, endpoint 2, bus reset flags
// - Writing one to bit 11 marks the endpoint 5 buffer empty
// - Writing one to bit 10 marks the endpoint 5 buffer full for sending
// - Writing one to bit 9 marks the endpoint 0 buffer empty
// - Writing one to bit 8 marks the endpoint 0 buffer full for sending
// - Writing one to bit 7 clears the suspend interrupt flag
// - Writing one to bit 6 signals remote wake-up toward the host
// - Bits 5 to 0 clear endpoint 5 and endpoint 0 write, read, setup flags
// - Bit 0 of soft reset register resets the interface; bits 15 to 1 ignored
// - Stall bits 5 to 0 stall endpoints 5 to 0; bits 15 to 6 unused
// - Setup bytes read as four words, lower byte first, ascending
// - Suspend status drops on host wake-up or on remote wake-up write
// - Bus reset on the link raises a sticky flag until cleared
// - Self-handled standard requests store no setup bytes, raise no setup flag
`timescale 1ns/1ps
module uic_regs #(
	parameter int SRST_HOLD = uic_pkg::SRST_HOLD_DEF
) (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [31:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [uic_pkg::DATA_W-1:0] WB_DAT_I,
	output logic [uic_pkg::DATA_W-1:0] WB_DAT_O,
	output logic WB_ACK_O,
	input wire logic EVT_EP4_ODD,
	input wire logic EVT_EP2_ODD,
	input wire logic EVT_BUS_RESET,
	input wire logic EVT_SUSPEND,
	input wire logic EVT_EP5_WRITE,
	input wire logic EVT_EP5_READ,
	input wire logic EVT_EP5_SETUP,
	input wire logic EVT_EP0_WRITE,
	input wire logic EVT_EP0_READ,
	input wire logic HOST_WAKEUP,
	input wire logic [3:0] ACK_STATUS,
	input wire logic DMA_DONE,
	input wire logic [7:0] SETUP_BYTE,
	input wire logic [2:0] SETUP_IDX,
	input wire logic SETUP_VALID,
	input wire logic SETUP_DONE,
	input wire logic SETUP_SELF_HANDLED,
	output logic [uic_pkg::NUM_EP-1:0] STALL_EP,
	output logic EP0_BUF_FULL,
	output logic EP5_BUF_FULL,
	output logic RESUME_PULSE,
	output logic SOFT_RESET,
	output logic IRQ
);
	import uic_pkg::*;

	// ****************************************
	// Parameter check
	// ****************************************
	generate
		if (SRST_HOLD < 1 || SRST_HOLD > 255) begin : g_bad
			$error("SRST_HOLD out of range");
		end
	endgenerate

	// ****************************************
	// Wishbone decode
	// ****************************************
	logic ack_q;
	logic [DATA_W-1:0] dat_q;
	logic [DATA_W-1:0] dat_d;
	wire [29:0] widx = WB_ADR_I[31:2];
	wire req = WB_CYC_I & WB_STB_I & ~ack_q;
	wire wr_go = req & WB_WE_I;
	wire rd_go = req & ~WB_WE_I;
	wire [REG_W-1:0] lane_m = {{8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
	wire [REG_W-1:0] wd = WB_DAT_I[REG_W-1:0] & lane_m;
	wire hit_flags = widx == IDX_FLAGS;
	wire hit_clr = widx == IDX_IRQ_CLR;
	wire hit_srst = widx == IDX_SOFT_RST;
	wire hit_stall = widx == IDX_STALL;
	wire hit_s12 = widx == IDX_SETUP_12;
	wire hit_s34 = widx == IDX_SETUP_34;
	wire hit_s56 = widx == IDX_SETUP_56;
	wire hit_s78 = widx == IDX_SETUP_78;
	wire hit_mask = widx == IDX_IRQ_MASK;
	wire clr_wr = wr_go & hit_clr;
	wire srst_wr = wr_go & hit_srst & wd[SRST_BIT];
	wire stall_wr = wr_go & hit_stall;
	wire mask_wr = wr_go & hit_mask;

	// ****************************************
	// Interrupt-clear and handoff pulses
	// ****************************************
	logic srst_q;
	logic [REG_W-1:0] flags_q;
	logic [REG_W-1:0] flags_d;
	logic [REG_W-1:0] mask_q;
	wire [REG_W-1:0] cw = clr_wr ? wd : 16'h0000;
	wire resume_wr = cw[RESUME];
	// Bit 15 of the written word is never looked at
	wire [REG_W-1:0] clr_vec = {cw[CLR_EP4], cw[CLR_EP2], 5'h00, cw[CLR_BUS_RST], cw[CLR_SUSP], 1'b0,
		cw[5:0]};
	wire setup_ev = SETUP_DONE & ~SETUP_SELF_HANDLED;
	wire [REG_W-1:0] set_vec = {EVT_EP4_ODD, EVT_EP2_ODD, 5'h00, EVT_BUS_RESET, EVT_SUSPEND, 1'b0,
		EVT_EP5_WRITE, EVT_EP5_READ, EVT_EP5_SETUP, EVT_EP0_WRITE, EVT_EP0_READ, setup_ev};
	wire susp_d = ~srst_q & (EVT_SUSPEND | (flags_q[FLG_SUSP_ST] & ~HOST_WAKEUP & ~resume_wr));
	wire [REG_W-1:0] lvl_vec = {2'b00, susp_d, ACK_STATUS, 2'b00, DMA_DONE, 6'h00};

	// ****************************************
	// Interrupt flags, set wins over clear
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < REG_W; gi++) begin : g_flag
			if (STICKY_MASK[gi]) begin : g_st
				assign flags_d[gi] = ~srst_q & (set_vec[gi] | (flags_q[gi] & ~clr_vec[gi]));
			end else begin : g_lv
				assign flags_d[gi] = lvl_vec[gi];
			end
		end
	endgenerate

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			flags_q <= 16'h0000;
		end else begin
			flags_q <= flags_d;
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			mask_q <= MASK_RST;
		end else if (mask_wr) begin
			mask_q <= (mask_q & ~lane_m) | wd;
		end
	end

	wire irq_d = |(flags_d & mask_q);

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= irq_d;
		end
	end

	// ****************************************
	// Buffer handoff and remote wake-up
	// ****************************************
	wire ep0_full_d = ~srst_q & (cw[EP0_FULL] | (EP0_BUF_FULL & ~cw[EP0_EMPTY]));
	wire ep5_full_d = ~srst_q & (cw[EP5_FULL] | (EP5_BUF_FULL & ~cw[EP5_EMPTY]));

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			EP0_BUF_FULL <= 1'b0;
			EP5_BUF_FULL <= 1'b0;
			RESUME_PULSE <= 1'b0;
		end else begin
			EP0_BUF_FULL <= ep0_full_d;
			EP5_BUF_FULL <= ep5_full_d;
			RESUME_PULSE <= resume_wr;
		end
	end

	// ****************************************
	// Software reset with self clear
	// ****************************************
	logic [CNT_W-1:0] srst_cnt_q;
	wire srst_done = srst_cnt_q == CNT_W'(SRST_HOLD - 1);

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			srst_q <= 1'b1;
			srst_cnt_q <= '0;
		end else if (srst_wr) begin
			srst_q <= 1'b1;
			srst_cnt_q <= '0;
		end else if (srst_q) begin
			srst_q <= ~srst_done;
			srst_cnt_q <= srst_cnt_q + CNT_W'(1);
		end
	end

	assign SOFT_RESET = srst_q;

	// ****************************************
	// Endpoint stall flags
	// ****************************************
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			STALL_EP <= STALL_RST[NUM_EP-1:0];
		end else if (stall_wr) begin
			STALL_EP <= (STALL_EP & ~lane_m[NUM_EP-1:0]) | wd[NUM_EP-1:0];
		end
	end

	// ****************************************
	// Setup packet capture
	// ****************************************
	logic [7:0] setup_sh_q [SETUP_N];
	logic [7:0] setup_q [SETUP_N];
	generate
		for (gi = 0; gi < SETUP_N; gi++) begin : g_setup
			always_ff @(posedge CORE_CLK or posedge RST) begin
				if (RST) begin
					setup_sh_q[gi] <= 8'h00;
					setup_q[gi] <= 8'h00;
				end else begin
					if (SETUP_VALID && SETUP_IDX == 3'(gi)) begin
						setup_sh_q[gi] <= SETUP_BYTE;
					end
					if (srst_q) begin
						setup_q[gi] <= 8'h00;
					end else if (setup_ev) begin
						setup_q[gi] <= setup_sh_q[gi];
					end
				end
			end
		end
	endgenerate

	// ****************************************
	// Read mux and bus answer
	// ****************************************
	wire [REG_W-1:0] rd_s12 = {setup_q[1], setup_q[0]};
	wire [REG_W-1:0] rd_s34 = {setup_q[3], setup_q[2]};
	wire [REG_W-1:0] rd_s56 = {setup_q[5], setup_q[4]};
	wire [REG_W-1:0] rd_s78 = {setup_q[7], setup_q[6]};
	wire [REG_W-1:0] rd_stall = {10'h000, STALL_EP};
	wire [REG_W-1:0] rd_mux = hit_flags ? flags_q :
		hit_stall ? rd_stall :
		hit_s12 ? rd_s12 :
		hit_s34 ? rd_s34 :
		hit_s56 ? rd_s56 :
		hit_s78 ? rd_s78 :
		hit_mask ? mask_q : 16'h0000;
	assign dat_d = rd_go ? {16'h0000, rd_mux} : 32'h0000_0000;

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			ack_q <= 1'b0;
			dat_q <= '0;
		end else begin
			ack_q <= req;
			dat_q <= dat_d;
		end
	end

	assign WB_ACK_O = ack_q;
	assign WB_DAT_O = dat_q;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (RST);

	sequence s_req;
		WB_CYC_I && WB_STB_I && !ack_q;
	endsequence
	sequence s_ack;
		ack_q ##1 !ack_q;
	endsequence

	chk_bus_ack_once: assert property (s_req |=> s_ack)
		else $error("bus ack not a single cycle");
	chk_clear_ep4_flag: assert property (clr_wr && wd[CLR_EP4] && !EVT_EP4_ODD |=> !flags_q[15])
		else $error("ep4 flag not cleared");
	chk_set_beats_clear: assert property (clr_wr && wd[0] && setup_ev && !srst_q |=> flags_q[0])
		else $error("setup event lost on clear");
	chk_ep0_handoff: assert property (clr_wr && wd[EP0_FULL] && !srst_q |=> EP0_BUF_FULL)
		else $error("ep0 buffer not full");
	chk_ep5_empty: assert property (clr_wr && wd[EP5_EMPTY] && !wd[EP5_FULL] |=> !EP5_BUF_FULL)
		else $error("ep5 buffer not empty");
	chk_resume_pulse: assert property (clr_wr && wd[RESUME] |=> RESUME_PULSE &&
		(!flags_q[FLG_SUSP_ST] || $past(EVT_SUSPEND)))
		else $error("resume did not end suspend");
	chk_srst_selfclear: assert property (srst_wr ##1 !srst_wr [*1] |-> ##[0:300] !srst_q)
		else $error("soft reset stuck");
	chk_srst_apply: assert property (srst_wr |=> SOFT_RESET ##1
		(!EP0_BUF_FULL && !EP5_BUF_FULL && (flags_q & STICKY_MASK) == 16'h0000))
		else $error("soft reset not applied");
	chk_stall_write: assert property (stall_wr && WB_SEL_I[0] |=> STALL_EP == $past(wd[NUM_EP-1:0]))
		else $error("stall flags not written");
	chk_setup_skip: assert property (SETUP_DONE && SETUP_SELF_HANDLED && !srst_q |=>
		$stable(rd_s12) && $stable(rd_s78))
		else $error("self handled setup stored");
	chk_irq_level: assert property (##1 IRQ == |($past(flags_d) & $past(mask_q)))
		else $error("irq level mismatch");

	// ****************************************
	// Further checks
	// ****************************************
	// Length of the soft reset pulse since its last start
	logic [CNT_W:0] srst_len_q;

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			srst_len_q <= '0;
		end else if (srst_wr) begin
			srst_len_q <= '0;
		end else if (srst_q) begin
			srst_len_q <= srst_len_q + (CNT_W + 1)'(1);
		end
	end

	chk_srst_length: assert property (srst_len_q <= (CNT_W + 1)'(SRST_HOLD))
		else $error("soft reset held too long");
	chk_clear_ep2_flag: assert property (clr_wr && wd[CLR_EP2] && !EVT_EP2_ODD |=> !flags_q[14])
		else $error("ep2 flag not cleared");
	chk_clear_busrst: assert property (clr_wr && wd[CLR_BUS_RST] && !EVT_BUS_RESET |=> !flags_q[8])
		else $error("bus reset flag not cleared");
	chk_bus_reset_set: assert property (EVT_BUS_RESET && !srst_q |=> flags_q[8])
		else $error("bus reset flag not set");
	chk_ep4_set: assert property (EVT_EP4_ODD && !srst_q |=> flags_q[15])
		else $error("ep4 flag not set");
	chk_clear_suspend: assert property (clr_wr && wd[CLR_SUSP] && !EVT_SUSPEND |=> !flags_q[7])
		else $error("suspend flag not cleared");

	chk_ep5_handoff: assert property (clr_wr && wd[EP5_FULL] && !srst_q |=> EP5_BUF_FULL)
		else $error("ep5 buffer not full");
	chk_ep0_empty: assert property (clr_wr && wd[EP0_EMPTY] && !wd[EP0_FULL] |=> !EP0_BUF_FULL)
		else $error("ep0 buffer not empty");
	chk_host_wakeup: assert property (HOST_WAKEUP && !EVT_SUSPEND |=> !flags_q[FLG_SUSP_ST])
		else $error("host wake-up did not end suspend");
	chk_setup_noflag: assert property (SETUP_DONE && SETUP_SELF_HANDLED && !flags_q[0] && !srst_q
		|=> !flags_q[0])
		else $error("self handled setup raised flag");

	chk_clear_reads_zero: assert property (rd_go && hit_clr |=> WB_DAT_O == 32'h0000_0000)
		else $error("clear register read not zero");
	chk_srst_reads_zero: assert property (rd_go && hit_srst |=> WB_DAT_O == 32'h0000_0000)
		else $error("soft reset register read not zero");
	chk_stall_upper: assert property (rd_go && hit_stall |=> WB_DAT_O[15:6] == 10'h000)
		else $error("stall upper bits not zero");
	chk_ack_level: assert property (##1 flags_q[12:9] == $past(ACK_STATUS) && flags_q[6] == $past(DMA_DONE))
		else $error("level flags mismatch");
endmodule : uic_regs

/* File: uic_host_model.sv */
// Far-side USB host model: link events and setup packets
`timescale 1ns/1ps
module uic_host_model (
	input wire logic clk,
	output logic [9:0] evt,
	output logic [7:0] sbyte,
	output logic [2:0] sidx,
	output logic svalid,
	output logic sdone,
	output logic sself
);
	// ****************************************
	// Idle levels and bench-called tasks
	// ****************************************
	initial begin
		evt = '0;
		sbyte = 8'h5a;
		sidx = 3'h0;
		svalid = 1'b0;
		sdone = 1'b0;
		sself = 1'b0;
	end
	task automatic pulse(input int n);
		@(posedge clk);
		evt[n] <= 1'b1;
		@(posedge clk);
		evt <= '0;
	endtask : pulse
	task automatic send_setup(input logic [63:0] pkt, input logic self_h);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			sbyte <= pkt[8*i +: 8];
			sidx <= i[2:0];
			svalid <= 1'b1;
		end
		@(posedge clk);
		svalid <= 1'b0;
		sbyte <= ~pkt[63:56];
		sdone <= 1'b1;
		sself <= self_h;
		@(posedge clk);
		sdone <= 1'b0;
		sself <= ~self_h;
	endtask : send_setup
endmodule : uic_host_model

/* File: test_usb_device_irq_clear_stall_setup.sv */
// Self-checking bench for the USB device control register block
`timescale 1ns/1ps
module test_usb_device_irq_clear_stall_setup;
	import uic_pkg::*;
	localparam int HOLD = 4;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic req = 1'b0;
	logic we = 1'b0;
	logic [31:0] adr = '0;
	logic [3:0] sel = '0;
	logic [31:0] wd = '0;
	logic [31:0] dat_o;
	logic ack;
	logic [9:0] evt;
	logic [7:0] sbyte;
	logic [2:0] sidx;
	logic sval, sdone, sself, full0, full5, res_p, srst, irq;
	logic [5:0] stall;
	logic [3:0] acks = 4'h0;
	logic dma = 1'b0;
	logic [31:0] r;
	int miscompares = 0;
	int num_checks = 0;
	int cycles = 0;
	int res_cnt = 0;
	int fb[9] = '{1, 2, 3, 4, 5, 7, 8, 14, 15};
	int cb[9] = '{1, 2, 3, 4, 5, 7, 12, 13, 14};
	logic [1:0] bx[4] = '{2'b01, 2'b00, 2'b10, 2'b00};
	logic [63:0] pkt = 64'h8877665544332211;
	always #2 clk = ~clk;
	uic_regs #(.SRST_HOLD(HOLD)) i_dut (.CORE_CLK(clk), .RST(rst), .WB_CYC_I(req), .WB_STB_I(req), .WB_WE_I(we),
		.WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wd), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
		.EVT_EP4_ODD(evt[8]), .EVT_EP2_ODD(evt[7]), .EVT_BUS_RESET(evt[6]), .EVT_SUSPEND(evt[5]),
		.EVT_EP5_WRITE(evt[4]), .EVT_EP5_READ(evt[3]), .EVT_EP5_SETUP(evt[2]), .EVT_EP0_WRITE(evt[1]),
		.EVT_EP0_READ(evt[0]), .HOST_WAKEUP(evt[9]), .ACK_STATUS(acks), .DMA_DONE(dma),
		.SETUP_BYTE(sbyte), .SETUP_IDX(sidx), .SETUP_VALID(sval), .SETUP_DONE(sdone),
		.SETUP_SELF_HANDLED(sself), .STALL_EP(stall), .EP0_BUF_FULL(full0), .EP5_BUF_FULL(full5),
		.RESUME_PULSE(res_p), .SOFT_RESET(srst), .IRQ(irq));
	uic_host_model i_host (.clk(clk), .evt(evt), .sbyte(sbyte), .sidx(sidx), .svalid(sval), .sdone(sdone),
		.sself(sself));
	// ****************************************
	// Tasks
	// ****************************************
	task automatic end_sim();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [29:0] idx, input logic [15:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		req <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		sel <= 4'h3;
		wd <= {16'h0000, d};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = dat_o;
		req <= 1'b0;
		if (n >= 50) begin
			miscompares++;
			end_sim();
		end
	endtask : wb
	task automatic settle();
		repeat (2) @(posedge clk);
		#1;
	endtask : settle
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (res_p === 1'b1) begin
			res_cnt <= res_cnt + 1;
		end
		if (cycles == 5000) begin
			miscompares++;
			end_sim();
		end
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (3) @(posedge clk);
		chk(32'(srst), 32'h1);
		chk(32'(stall), 32'h1);
		rst <= 1'b0;
		repeat (HOLD + 3) @(posedge clk);
		wb(1'b0, IDX_STALL, 16'h0, r);
		chk(r, 32'h1);
		wb(1'b1, IDX_STALL, 16'hffff, r);
		wb(1'b0, IDX_STALL, 16'h0, r);
		chk(r, 32'h3f);
		wb(1'b1, IDX_STALL, 16'h0012, r);
		settle();
		chk(32'(stall), 32'h12);
		wb(1'b0, IDX_IRQ_CLR, 16'h0, r);
		chk(r, 32'h0);
		wb(1'b1, IDX_IRQ_MASK + 30'h1, 16'hffff, r);
		wb(1'b0, IDX_IRQ_MASK + 30'h1, 16'h0, r);
		chk(r, 32'h0);
		for (int i = 0; i < 9; i++) begin
			i_host.pulse(i);
			wb(1'b1, IDX_IRQ_CLR, 16'h8000, r);
			wb(1'b0, IDX_FLAGS, 16'h0, r);
			chk(r & 32'hc1bf, 32'h1 << fb[i]);
			wb(1'b1, IDX_IRQ_CLR, 16'h1 << cb[i], r);
			wb(1'b0, IDX_FLAGS, 16'h0, r);
			chk(r & 32'hc1bf, 32'h0);
		end
		wb(1'b0, IDX_FLAGS, 16'h0, r);
		chk(r & 32'h2000, 32'h2000);
		wb(1'b1, IDX_IRQ_CLR, 16'h0040, r);
		settle();
		chk(32'(res_cnt), 32'h1);
		wb(1'b0, IDX_FLAGS, 16'h0, r);
		chk(r & 32'h2000, 32'h0);
		i_host.pulse(5);
		wb(1'b0, IDX_FLAGS, 16'h0, r);
		chk(r & 32'h2000, 32'h2000);
		i_host.pulse(9);
		wb(1'b0, IDX_FLAGS, 16'h0, r);
		chk(r & 32'h2000, 32'h0);
		wb(1'b1, IDX_IRQ_MASK, 16'h0004, r);
		i_host.pulse(0);
		settle();
		chk(32'(irq), 32'h0);
		i_host.pulse(1);
		settle();
		chk(32'(irq), 32'h1);
		wb(1'b1, IDX_IRQ_CLR, 16'h0006, r);
		settle();
		chk(32'(irq), 32'h0);
		for (int j = 0; j < 4; j++) begin
			wb(1'b1, IDX_IRQ_CLR, 16'h0100 << j, r);
			settle();
			chk(32'({full5, full0}), 32'(bx[j]));
		end
		i_host.send_setup(pkt, 1'b1);
		wb(1'b0, IDX_SETUP_12, 16'h0, r);
		chk(r, 32'h0);
		wb(1'b0, IDX_FLAGS, 16'h0, r);
		chk(r & 32'h1, 32'h0);
		i_host.send_setup(pkt, 1'b0);
		for (int k = 0; k < 4; k++) begin
			wb(1'b0, IDX_SETUP_12 + 30'(2 * k), 16'h0, r);
			chk(r, {16'h0000, pkt[16*k +: 16]});
		end
		wb(1'b0, IDX_FLAGS, 16'h0, r);
		chk(r & 32'h1, 32'h1);
		@(posedge clk);
		acks <= 4'h9;
		dma <= 1'b1;
		wb(1'b0, IDX_FLAGS, 16'h0, r);
		chk(r & 32'h1e40, 32'h1240);
		@(posedge clk);
		acks <= 4'h6;
		dma <= 1'b0;
		wb(1'b0, IDX_FLAGS, 16'h0, r);
		chk(r & 32'h1e40, 32'h0c00);
		@(posedge clk);
		acks <= 4'h0;
		wb(1'b1, IDX_SOFT_RST, 16'hfffe, r);
		settle();
		chk(32'(srst), 32'h0);
		wb(1'b1, IDX_SOFT_RST, 16'h0001, r);
		settle();
		chk(32'(srst), 32'h1);
		repeat (HOLD + 2) @(posedge clk);
		chk(32'(srst), 32'h0);
		wb(1'b0, IDX_SETUP_12, 16'h0, r);
		chk(r, 32'h0);
		end_sim();
	end
endmodule : test_usb_device_irq_clear_stall_setup
